// file: hdl/multichannel_serial_port.v
`timescale 1ns/1ps
`include "spi_port_defs.vh"
module multichannel_serial_port (
   // clock and reset
   input  wire                mclk_in,
   input  wire                resetn_in,
   // mode and channel control
   input  wire                master_mode_in,
   input  wire                single_mode_in,
   input  wire                clk_pol_in,
   input  wire                cs_pol_in,
   input  wire                force_cs_in,
   input  wire                chan_enable_in,
   // transmit data
   input  wire [`WORD_W-1:0]  tx_data_in,
   input  wire                tx_valid_in,
   output reg                 tx_ready_out,
   // receive data
   output reg  [`WORD_W-1:0]  rx_data_out,
   output reg                 rx_valid_out,
   // status
   output reg                 underflow_out,
   // link pins, master drives, slave samples
   input  wire                sclk_in,
   input  wire                cs_in,
   input  wire                mosi_in,
   output reg                 sclk_out,
   output reg                 sclk_oe_out,
   output reg                 cs_out,
   output reg                 cs_oe_out,
   output reg                 mosi_out,
   output reg                 mosi_oe_out
);
   reg        rst_meta_reg;
   reg        rst_sync_reg;
   wire       rst_n;
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // link inputs pass two flops before use
   reg [2:0] sclk_sync_reg;
   reg [2:0] cs_sync_reg;
   reg [1:0] mosi_sync_reg;
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_reg <= {3{`CLK_POL_RST}};
         cs_sync_reg   <= {3{`CS_POL_RST}};
         mosi_sync_reg <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
         cs_sync_reg   <= {cs_sync_reg[1:0], cs_in};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
      end
   end
   wire sclk_s = sclk_sync_reg[1];
   wire cs_s   = cs_sync_reg[1];
   wire cs_tog = cs_sync_reg[1] ^ cs_sync_reg[2];
   wire sclk_tog = sclk_sync_reg[1] ^ sclk_sync_reg[2];

   // transmit buffer
   wire [`WORD_W-1:0] fifo_data;
   wire               fifo_valid;
   wire               fifo_ready;
   wire               tx_push = tx_valid_in & tx_ready_out;
   spi_fifo #(
      .WIDTH (`WORD_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) tx_fifo (
      .clk_in     (mclk_in),
      .rst_n_in   (rst_n),
      .wdata_in   (tx_data_in),
      .wvalid_in  (tx_push),
      .wready_out (),
      .rdata_out  (fifo_data),
      .rvalid_out (fifo_valid),
      .rready_in  (fifo_ready)
   );

   // own occupancy count: a registered ready must not offer a slot
   // on the very cycle the buffer fills, or that word would be lost
   reg  [`FIFO_AW:0]  fill_reg;
   wire [`FIFO_AW:0]  fill_next = fill_reg
                                 + {{`FIFO_AW{1'b0}}, tx_push}
                                 - {{`FIFO_AW{1'b0}}, fifo_ready};
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n)
         fill_reg <= {(`FIFO_AW+1){1'b0}};
      else
         fill_reg <= fill_next;
   end

   // bus polarity latched only on channel enable or single-mode exit
   reg        pol_live_reg;
   reg        clk_pol_reg;
   reg        cs_pol_reg;
   reg        single_d_reg;
   reg        enable_d_reg;
   wire       enable_rise = chan_enable_in & ~enable_d_reg;
   wire       single_fall = ~single_mode_in & single_d_reg;
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         clk_pol_reg  <= `CLK_POL_RST;
         cs_pol_reg   <= `CS_POL_RST;
         pol_live_reg <= 1'b0;
         single_d_reg <= 1'b0;
         enable_d_reg <= 1'b0;
      end else begin
         single_d_reg <= single_mode_in;
         enable_d_reg <= chan_enable_in;
         if (master_mode_in && (enable_rise || single_fall)) begin
            clk_pol_reg  <= clk_pol_in;
            cs_pol_reg   <= cs_pol_in;
            pol_live_reg <= 1'b1;
         end
      end
   end

   // master sequencer
   reg [1:0]          state_reg;
   reg [1:0]          state_next;
   reg [`CNT_W-1:0]   div_reg;
   reg [`CNT_W-1:0]   bit_reg;
   reg [`WORD_W-1:0]  shift_reg;
   reg                sclk_phase_reg;
   wire               div_hit = (div_reg == `DIV_LAST);
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_IDLE:  if (chan_enable_in && fifo_valid && master_mode_in)
                       state_next = `ST_SEL;
         `ST_SEL:   state_next = `ST_SHIFT;
         `ST_SHIFT: if (div_hit && sclk_phase_reg && bit_reg == `BIT_LAST)
                       state_next = `ST_DONE;
         `ST_DONE:  state_next = `ST_IDLE;
         default:   state_next = `ST_IDLE;
      endcase
   end
   wire master_load = (state_reg == `ST_SEL);
   wire slave_load  = ~master_mode_in & chan_enable_in & cs_tog;
   assign fifo_ready = (master_load | slave_load) & fifo_valid;

   // asserted select level in force or active transfer
   wire cs_active = force_cs_in | (state_reg != `ST_IDLE);
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= `ST_IDLE;
         div_reg        <= `BIT_RST;
         bit_reg        <= `BIT_RST;
         shift_reg      <= {`WORD_W{1'b0}};
         sclk_phase_reg <= 1'b0;
         rx_data_out    <= {`WORD_W{1'b0}};
         rx_valid_out   <= 1'b0;
         underflow_out  <= 1'b0;
         tx_ready_out   <= 1'b0;
         sclk_out       <= `CLK_POL_RST;
         cs_out         <= `CS_POL_RST;
         mosi_out       <= 1'b0;
         sclk_oe_out    <= 1'b0;
         cs_oe_out      <= 1'b0;
         mosi_oe_out    <= 1'b0;
      end else begin
         state_reg    <= state_next;
         tx_ready_out <= (fill_next != `FIFO_FULL);
         rx_valid_out <= 1'b0;
         underflow_out <= 1'b0;
         sclk_oe_out  <= master_mode_in;
         cs_oe_out    <= master_mode_in;
         mosi_oe_out  <= master_mode_in;
         // before polarity goes live the pins sit at reset polarity
         sclk_out <= (pol_live_reg ? clk_pol_reg : `CLK_POL_RST)
                     ^ sclk_phase_reg;
         cs_out   <= (pol_live_reg ? cs_pol_reg : `CS_POL_RST)
                     ^ cs_active;
         mosi_out <= shift_reg[`WORD_W-1];
         if (master_load) begin
            shift_reg <= fifo_data;
            div_reg   <= `BIT_RST;
            bit_reg   <= `BIT_RST;
         end else if (state_reg == `ST_SHIFT) begin
            div_reg <= div_hit ? `BIT_RST : div_reg + `ONE_BIT;
            if (div_hit) begin
               sclk_phase_reg <= ~sclk_phase_reg;
               if (sclk_phase_reg) begin
                  shift_reg <= {shift_reg[`WORD_W-2:0], mosi_sync_reg[1]};
                  bit_reg   <= bit_reg + `ONE_BIT;
               end
            end
         end else if (state_reg == `ST_DONE) begin
            rx_data_out    <= shift_reg;
            rx_valid_out   <= 1'b1;
            sclk_phase_reg <= 1'b0;
         end
         // slave side: any select transition while the channel is enabled tries a load
         if (slave_load) begin
            if (fifo_valid)
               shift_reg <= fifo_data;
            else
               underflow_out <= 1'b1;
            bit_reg <= `BIT_RST;
         end else if (!master_mode_in && chan_enable_in && sclk_tog
                      && sclk_s != cs_s) begin
            // sample on clock edges whose new level differs from select
            shift_reg <= {shift_reg[`WORD_W-2:0], mosi_sync_reg[1]};
            bit_reg   <= bit_reg + `ONE_BIT;
            if (bit_reg == `BIT_LAST) begin
               rx_data_out  <= {shift_reg[`WORD_W-2:0], mosi_sync_reg[1]};
               rx_valid_out <= 1'b1;
            end
         end
      end
   end
endmodule // multichannel_serial_port

// file: hdl/spi_fifo.v
`timescale 1ns/1ps
module spi_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk_in,
   input  wire             rst_n_in,
   // fill side
   input  wire [WIDTH-1:0] wdata_in,
   input  wire             wvalid_in,
   output wire             wready_out,
   // drain side
   output wire [WIDTH-1:0] rdata_out,
   output wire             rvalid_out,
   input  wire             rready_in
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW:0]      wptr_reg;
   reg [AW:0]      rptr_reg;
   wire            full;
   wire            empty;
   assign full  = (wptr_reg[AW] != rptr_reg[AW]) &&
                  (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
   assign empty = (wptr_reg == rptr_reg);
   assign wready_out = ~full;
   assign rvalid_out = ~empty;
   assign rdata_out  = mem_reg[rptr_reg[AW-1:0]];
   always @(posedge clk_in) begin
      if (wvalid_in && !full)
         mem_reg[wptr_reg[AW-1:0]] <= wdata_in;
   end
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wptr_reg <= {(AW+1){1'b0}};
         rptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (wvalid_in && !full)
            wptr_reg <= wptr_reg + 1'b1;
         if (rready_in && !empty)
            rptr_reg <= rptr_reg + 1'b1;
      end
   end
endmodule // spi_fifo

// file: pkg/spi_port_defs.vh
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH
// serial word and buffer shape
`define WORD_W        8
`define FIFO_DEPTH    32
`define FIFO_AW       5
// occupancy at which no further word is offered ready
`define FIFO_FULL     6'h20
`define CNT_W         4
// reset-state polarities of the link lines
`define CLK_POL_RST   1'b0
`define CS_POL_RST    1'b0
`define BIT_RST       4'h0
`define BIT_LAST      4'h7
`define ONE_BIT       4'h1
`define DIV_LAST      4'h9
// master sequencer states
`define ST_IDLE       2'h0
`define ST_SEL        2'h1
`define ST_SHIFT      2'h2
`define ST_DONE       2'h3
`endif

// file: test/serial_port_monitor.sv
`timescale 1ns/1ps
`include "spi_port_defs.vh"
module serial_port_monitor (
   input wire mclk_in,
   input wire resetn_in,
   input wire master_mode_in,
   input wire single_mode_in,
   input wire clk_pol_in,
   input wire cs_pol_in,
   input wire chan_enable_in,
   input wire force_cs_in,
   input wire tx_valid_in,
   input wire tx_ready_out,
   input wire underflow_out,
   input wire cs_in,
   input wire sclk_out,
   input wire cs_out,
   input wire cs_oe_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   logic       en_seen_reg;
   logic       pushed_reg;
   logic [5:0] cs_hist_reg;
   // first enable or single-mode exit after reset repolarises the pins
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_seen_reg <= 1'b0;
         pushed_reg  <= 1'b0;
         cs_hist_reg <= 6'h00;
      end else begin
         en_seen_reg <= en_seen_reg | (master_mode_in
                        & (chan_enable_in | $fell(single_mode_in)));
         pushed_reg  <= pushed_reg | (tx_valid_in & tx_ready_out);
         cs_hist_reg <= {cs_hist_reg[4:0], cs_in};
      end
   end
   sequence idle_master;
      (master_mode_in && cs_oe_out && !chan_enable_in && !force_cs_in
         && !$fell(single_mode_in)) [*3];
   endsequence
   sequence single_exit;
      (master_mode_in && !chan_enable_in && !force_cs_in
         && $fell(single_mode_in)) ##1 (!chan_enable_in && !force_cs_in);
   endsequence
   sequence first_enable;
      master_mode_in && !en_seen_reg && $rose(chan_enable_in);
   endsequence
   AST_HOLD: assert property (idle_master |-> $stable(cs_out))
      else $error("select moved before enable");
   AST_CS_EDGE: assert property (first_enable ##0
      (cs_pol_in != `CS_POL_RST) |-> ##[1:2] $rose(cs_out))
      else $error("select did not move at first enable");
   AST_CLK_EDGE: assert property (first_enable ##0
      (clk_pol_in != `CLK_POL_RST) |-> ##[1:2] $changed(sclk_out))
      else $error("clock did not move at first enable");
   AST_UFL: assert property (!master_mode_in && chan_enable_in
      && !pushed_reg && $changed(cs_in) |-> ##[3:5] underflow_out)
      else $error("no underflow after select edge");
   AST_UFL_CAUSE: assert property (underflow_out |->
      cs_hist_reg[5:1] != 5'h00 && cs_hist_reg[5:1] != 5'h1f)
      else $error("underflow without select edge");
   AST_PULSE: assert property (underflow_out |=> !underflow_out)
      else $error("underflow longer than one cycle");
   AST_SINGLE_EXIT: assert property (single_exit |-> ##1
      (cs_out == $past(cs_pol_in, 2)))
      else $error("select level not updated at single-mode exit");
endmodule // serial_port_monitor
bind multichannel_serial_port serial_port_monitor mon_u (.mclk_in,
   .resetn_in, .master_mode_in, .single_mode_in, .clk_pol_in, .cs_pol_in,
   .chan_enable_in, .force_cs_in, .tx_valid_in, .tx_ready_out,
   .underflow_out, .cs_in, .sclk_out, .cs_out, .cs_oe_out);

// file: test/spi_far_model.sv
`timescale 1ns/1ps
module spi_far_model (
   output logic sclk_out,
   output logic cs_out,
   output logic mosi_out
);
   initial begin
      sclk_out = 1'b0;
      cs_out   = 1'b0;
      mosi_out = 1'b0;
   end
   task automatic set_cs(input logic lvl);
      cs_out = lvl;
   endtask
   // link clock stands still outside frames
   task automatic frame(input logic [7:0] data);
      cs_out = ~cs_out;
      for (int i = 7; i >= 0; i--) begin
         mosi_out = data[i];
         #200 sclk_out = 1'b1;
         #200 sclk_out = 1'b0;
      end
      mosi_out = ~data[0];
      #200 cs_out = ~cs_out;
   endtask
endmodule // spi_far_model

// file: test/tb_multichannel_serial_port.sv
`timescale 1ns/1ps
`include "spi_port_defs.vh"
module tb_multichannel_serial_port;
   logic mclk_in, resetn_in, master_mode_in, single_mode_in, clk_pol_in;
   logic cs_pol_in, force_cs_in, chan_enable_in, tx_valid_in, tx_ready_out;
   logic rx_valid_out, underflow_out, sclk_in, cs_in, mosi_in, sclk_out;
   logic sclk_oe_out, cs_out, cs_oe_out, mosi_out, mosi_oe_out, cs0, ck0;
   logic [7:0] tx_data_in, rx_data_out;
   int         n_fail = 0, checked = 0, n_ufl = 0, u0, k;
   // {cs pol, clk pol, select moves, clock moves}
   logic [3:0] rows [4] = '{4'h0, 4'ha, 4'h5, 4'hf};
   multichannel_serial_port dut_u (.mclk_in, .resetn_in, .master_mode_in,
      .single_mode_in, .clk_pol_in, .cs_pol_in, .force_cs_in,
      .chan_enable_in, .tx_data_in, .tx_valid_in, .tx_ready_out,
      .rx_data_out, .rx_valid_out, .underflow_out, .sclk_in, .cs_in,
      .mosi_in, .sclk_out, .sclk_oe_out, .cs_out, .cs_oe_out, .mosi_out,
      .mosi_oe_out);
   spi_far_model far_u (.sclk_out(sclk_in), .cs_out(cs_in),
      .mosi_out(mosi_in));
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) if (underflow_out === 1'b1) n_ufl++;
   task automatic chk(input string what, input logic seen, exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic do_reset;
      resetn_in = 1'b0;
      cyc(12);
      resetn_in = 1'b1;
      cyc(4);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      {master_mode_in, single_mode_in, clk_pol_in, cs_pol_in} = 4'h0;
      {force_cs_in, chan_enable_in, tx_valid_in, resetn_in} = 4'h0;
      tx_data_in = 8'h00;
      foreach (rows[i]) begin
         master_mode_in = 1'b1;
         do_reset;
         {cs_pol_in, clk_pol_in} = rows[i][3:2];
         cs0 = cs_out;
         ck0 = sclk_out;
         chk("cs at reset polarity", cs0, `CS_POL_RST);
         chk("drivers on as master",
             {sclk_oe_out, cs_oe_out, mosi_oe_out} == 3'h7, 1'b1);
         cyc(4);
         chk("cs before enable", cs_out, cs0);
         chk("sclk before enable", sclk_out, ck0);
         chan_enable_in = 1'b1;
         cyc(3);
         chk("cs at enable", cs_out ^ cs0, rows[i][1]);
         chk("sclk at enable", sclk_out ^ ck0, rows[i][0]);
         chk("cs idle level", cs_out, rows[i][3]);
         chan_enable_in = 1'b0;
         $display("row %0d done", i);
      end
      // one word out as master: first bit on the pin, then done pulse
      tx_data_in = 8'h80;
      tx_valid_in = 1'b1;
      cyc(1);
      tx_valid_in = 1'b0;
      chan_enable_in = 1'b1;
      cyc(4);
      chk("first bit out", mosi_out, 1'b1);
      for (k = 0; k < 200 && rx_valid_out !== 1'b1; k++) cyc(1);
      chk("master word done", k < 200, 1'b1);
      chan_enable_in = 1'b0;
      $display("master transfer test done");
      // master init order: polarity lands before the channel enables
      do_reset;
      single_mode_in = 1'b1;
      cyc(1);
      {cs_pol_in, clk_pol_in} = 2'h3;
      cyc(1);
      force_cs_in = 1'b1;
      cyc(2);
      force_cs_in = 1'b0;
      cyc(2);
      single_mode_in = 1'b0;
      cyc(3);
      chk("cs after single exit", cs_out, 1'b1);
      chan_enable_in = 1'b1;
      cyc(3);
      chk("no select edge at enable", cs_out, 1'b1);
      chk("sclk after enable", sclk_out, 1'b1);
      chan_enable_in = 1'b0;
      $display("master init order test done");
      // slave facing a repolarised master, nothing queued
      master_mode_in = 1'b0;
      do_reset;
      chan_enable_in = 1'b1;
      cyc(2);
      u0 = n_ufl;
      far_u.set_cs(1'b1);
      cyc(8);
      chk("underflow on select edge", n_ufl == u0 + 1, 1'b1);
      cyc(20);
      chk("quiet while select holds", n_ufl == u0 + 1, 1'b1);
      chk("drivers off as slave",
          {sclk_oe_out, cs_oe_out, mosi_oe_out} == 3'h0, 1'b1);
      // far end settles its polarity before the slave enables
      chan_enable_in = 1'b0;
      far_u.set_cs(1'b0);
      cyc(8);
      u0 = n_ufl;
      far_u.set_cs(1'b1);
      cyc(8);
      chan_enable_in = 1'b1;
      cyc(8);
      chk("no underflow on late enable", n_ufl == u0, 1'b1);
      $display("slave edge test done");
      // both select edges of a frame find a word
      tx_data_in = 8'ha5;
      tx_valid_in = 1'b1;
      cyc(2);
      tx_valid_in = 1'b0;
      u0 = n_ufl;
      far_u.frame(8'h3c);
      cyc(8);
      chk("no underflow with data", n_ufl == u0, 1'b1);
      chk("word received", rx_data_out == 8'h3c, 1'b1);
      // fill until refused, then drain one word per select edge
      tx_valid_in = 1'b1;
      for (k = 0; k < 40 && tx_ready_out === 1'b1; k++) cyc(1);
      tx_valid_in = 1'b0;
      chk("words before refusal", k == `FIFO_DEPTH, 1'b1);
      u0 = n_ufl;
      for (k = 0; k <= `FIFO_DEPTH; k++) begin
         far_u.set_cs(~cs_in);
         cyc(8);
      end
      chk("underflow once drained", n_ufl == u0 + 1, 1'b1);
      $display("buffer test done");
      end_of_test;
   end
endmodule // tb_multichannel_serial_port
